// ===== irq_status_pkg.sv
// Constants for the interrupt status and mask logic
package irq_status_pkg;
    // Three status/mask pairs: audio, monitors, LEDs plus boost
    localparam int unsigned NUM_GROUPS = 3;
    localparam int unsigned GROUP_W    = 8;

    localparam int unsigned GRP_AUDIO  = 0;
    localparam int unsigned GRP_MON    = 1;
    localparam int unsigned GRP_LEDBST = 2;

    localparam logic [GROUP_W-1:0] STATUS_RST = 8'h00;
    localparam logic [GROUP_W-1:0] SERVED_RST = 8'h00;
    localparam logic [GROUP_W-1:0] COND_RST   = 8'h00;
    // Request pin released after reset
    localparam logic               INT_B_RST  = 1'b1;
endpackage

// ===== irq_status_mask.sv
// Sticky interrupt status, per-event masking and active-low request output
// Operation
// - Unmasked event sets status, asserts request
// - Masked event sets status, request untouched
// - Mask bit one suppresses that event
// - Request holds until unmasked set bits read or masked
// - Status sticky, read clears if condition gone
// - Read with condition present drops request only
// - Three status registers, each with mask
`timescale 1ns/100ps
module irq_status_mask (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_audio_cond,
    input  wire logic [7:0] i_mon_cond,
    input  wire logic [7:0] i_ledbst_cond,
    input  wire logic [7:0] i_audio_mask,
    input  wire logic [7:0] i_mon_mask,
    input  wire logic [7:0] i_ledbst_mask,
    input  wire logic       i_audio_rd,
    input  wire logic       i_mon_rd,
    input  wire logic       i_ledbst_rd,
    output logic      [7:0] o_audio_status,
    output logic      [7:0] o_mon_status,
    output logic      [7:0] o_ledbst_status,
    output logic            o_int_b
);

    localparam int unsigned NG = irq_status_pkg::NUM_GROUPS;
    localparam int unsigned GW = irq_status_pkg::GROUP_W;

    // ============================================================
    // Group gathering
    // ============================================================
    logic [GW-1:0] cond     [NG];
    logic [GW-1:0] mask     [NG];
    logic [NG-1:0] rd;

    // Per-group state
    logic [GW-1:0] status_reg  [NG];
    logic [GW-1:0] status_next [NG];
    logic [GW-1:0] served_reg  [NG];
    logic [GW-1:0] served_next [NG];
    logic [GW-1:0] cond_reg    [NG];
    logic [GW-1:0] cond_next   [NG];

    // Per-group decode of the current cycle
    logic [GW-1:0] rise        [NG];
    logic [GW-1:0] clr         [NG];
    logic [GW-1:0] kept        [NG];
    logic [GW-1:0] unmasked    [NG];
    logic [GW-1:0] pend        [NG];
    logic          grp_pend    [NG];

    // Request pin
    logic          any_pend;
    logic          int_b_reg;
    logic          int_b_next;

    // Three register groups, each with its own mask
    // Audio
    assign cond[irq_status_pkg::GRP_AUDIO]  = i_audio_cond;
    assign mask[irq_status_pkg::GRP_AUDIO]  = i_audio_mask;
    assign rd[irq_status_pkg::GRP_AUDIO]    = i_audio_rd;

    // Monitors
    assign cond[irq_status_pkg::GRP_MON]    = i_mon_cond;
    assign mask[irq_status_pkg::GRP_MON]    = i_mon_mask;
    assign rd[irq_status_pkg::GRP_MON]      = i_mon_rd;

    // LEDs plus boost converter
    assign cond[irq_status_pkg::GRP_LEDBST] = i_ledbst_cond;
    assign mask[irq_status_pkg::GRP_LEDBST] = i_ledbst_mask;
    assign rd[irq_status_pkg::GRP_LEDBST]   = i_ledbst_rd;

    // ============================================================
    // Condition history
    // ============================================================
    // Conditions share this clock, so they enter without a synchroniser
    generate
        // One copy per register group
        for (genvar gh = 0; gh < NG; gh++) begin : g_hist
            always_comb begin
                cond_next[gh] = cond[gh];

                // Only a 0 to 1 step counts as a new occurrence
                rise[gh]      = cond[gh] & ~cond_reg[gh];
            end

            // Synchronous reset to idle values
            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_b) begin
                    cond_reg[gh] <= irq_status_pkg::COND_RST;
                end else begin
                    cond_reg[gh] <= cond_next[gh];
                end
            end

        end
    endgenerate

    // ============================================================
    // Sticky status
    // ============================================================
    // Mask never gates status, so software still sees masked events
    generate
        // One copy per register group
        for (genvar gs = 0; gs < NG; gs++) begin : g_stat
            always_comb begin
                clr[gs]  = 8'h00;
                kept[gs] = 8'h00;
                // Read clears only bits whose condition is gone
                if (rd[gs]) begin
                    clr[gs]  = status_reg[gs] & ~cond[gs];
                    kept[gs] = status_reg[gs] & cond[gs];
                end

                // Condition sets status; set beats clear
                status_next[gs] = (status_reg[gs] & ~clr[gs]) | cond[gs];
            end

            // Synchronous reset to idle values
            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_b) begin
                    status_reg[gs] <= irq_status_pkg::STATUS_RST;
                end else begin
                    status_reg[gs] <= status_next[gs];
                end
            end

        end
    endgenerate

    // ============================================================
    // Served bits
    // ============================================================
    // A served bit stays set but raises nothing until re-armed
    generate
        // One copy per register group
        for (genvar gv = 0; gv < NG; gv++) begin : g_serv
            always_comb begin
                served_next[gv] = served_reg[gv];
                // Read while present drops request only
                if (rd[gv]) begin
                    served_next[gv] = served_reg[gv] | kept[gv];
                end

                // A read in the cycle a condition rises leaves it pending
                served_next[gv] = served_next[gv] & ~rise[gv];

                // Cleared status drops its served mark
                served_next[gv] = served_next[gv] & status_next[gv];
            end

            // Synchronous reset to idle values
            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_b) begin
                    served_reg[gv] <= irq_status_pkg::SERVED_RST;
                end else begin
                    served_reg[gv] <= served_next[gv];
                end
            end

        end
    endgenerate

    // ============================================================
    // Pending
    // ============================================================
    // Mask acts in the same cycle that it changes
    generate
        // One copy per register group
        for (genvar gp = 0; gp < NG; gp++) begin : g_pend
            always_comb begin
                unmasked[gp] = status_next[gp] & ~mask[gp];
                pend[gp]     = unmasked[gp] & ~served_next[gp];

                grp_pend[gp] = |pend[gp];
            end
        end
    endgenerate

    // ============================================================
    // Request pin
    // ============================================================
    // Registered from next-state values so the pin never glitches and changes on the same edge as status
    // Low while any unmasked unread bit pends
    always_comb begin
        any_pend = 1'b0;

        for (int i = 0; i < NG; i++) begin
            if (grp_pend[i]) begin
                any_pend = 1'b1;
            end
        end
        int_b_next = ~any_pend;
    end

    // Synchronous reset releases the pin
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            int_b_reg <= irq_status_pkg::INT_B_RST;
        end else begin
            int_b_reg <= int_b_next;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    // Host samples status in the read cycle, before the clear lands
    assign o_audio_status  = status_reg[irq_status_pkg::GRP_AUDIO];
    assign o_mon_status    = status_reg[irq_status_pkg::GRP_MON];
    assign o_ledbst_status = status_reg[irq_status_pkg::GRP_LEDBST];
    // Request pin from its own register
    assign o_int_b         = int_b_reg;

endmodule // irq_status_mask

// ===== irq_status_mask_checker.sv
// Checker of the sticky status and request pin behaviour
`timescale 1ns/100ps
module irq_status_mask_checker (input wire logic i_sys_clk, i_rst_b, i_audio_rd, i_mon_rd,
    i_ledbst_rd, o_int_b, input wire logic [7:0] i_audio_cond, i_mon_cond, i_ledbst_cond,
    i_audio_mask, i_mon_mask, i_ledbst_mask, o_audio_status, o_mon_status, o_ledbst_status);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic [23:0] masks = {i_audio_mask, i_mon_mask, i_ledbst_mask};
    sequence s_rd_held;
        i_audio_rd && $past(i_rst_b) && i_audio_cond == $past(i_audio_cond);
    endsequence
    property s_hold_rd_ok;
        s_rd_held ##0 {i_mon_cond, i_ledbst_cond, o_mon_status, o_ledbst_status} == 0 |=> o_int_b;
    endproperty
    a_bit_set: assert property (i_audio_cond != 0 |=>
        (o_audio_status & $past(i_audio_cond)) == $past(i_audio_cond)) else $error("set");
    a_bit_sticky: assert property (!i_mon_rd |=> ($past(o_mon_status) & ~o_mon_status) == 0)
        else $error("sticky");
    a_read_clear: assert property (i_ledbst_rd |=> o_ledbst_status == $past(i_ledbst_cond))
        else $error("clear");
    a_req_raise: assert property ((i_mon_cond & ~$past(i_mon_cond) & ~i_mon_mask) != 0
        |=> !o_int_b) else $error("raise");
    a_mask_quiet: assert property (&masks |=> o_int_b) else $error("mask");
    a_req_hold: assert property ($rose(o_int_b) && $past(i_rst_b) |->
        $past(i_audio_rd | i_mon_rd | i_ledbst_rd) || $past(masks) != $past(masks, 2))
        else $error("hold");
    a_low_pending: assert property (!o_int_b |->
        (o_audio_status | o_mon_status | o_ledbst_status) != 0) else $error("pin");
    a_served_rd: assert property (s_hold_rd_ok) else $error("served");
endmodule // irq_status_mask_checker

// ===== host_reader_model.sv
// Host that reads status after reset and while a request is pending
`timescale 1ns/100ps
module host_reader_model (input wire logic i_sys_clk, i_rst_b, i_int_b, output logic [2:0] o_rd);
    logic [1:0] up_reg = 2'h0, turn_reg = 2'h0;
    initial o_rd = 3'h0;
    always @(posedge i_sys_clk) up_reg <= {up_reg[0], i_rst_b};
    always @(negedge i_sys_clk) begin
        turn_reg <= (turn_reg == 2'h2) ? 2'h0 : turn_reg + 2'h1;
        o_rd <= (up_reg == 2'h1) ? 3'h7 : (i_int_b ? 3'h0 : 3'h1 << turn_reg);
    end
endmodule // host_reader_model

// ===== tb_irq_status_mask.sv
// Self-checking bench for the interrupt status logic
`timescale 1ns/100ps
module tb_irq_status_mask;
    logic       clk = 1'b0, rst_b = 1'b0, int_b, mi, lo;
    logic [2:0] rd;
    logic [7:0] c [3], m [3], st [3], ms [3], sv [3], pc [3], ns, nv;
    int         n_fail = 0, tests_run = 0, seed = 32'h3a92, k;
    always #10 clk = ~clk;
    irq_status_mask uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_audio_cond(c[0]), .i_mon_cond(c[1]),
        .i_ledbst_cond(c[2]), .i_audio_mask(m[0]), .i_mon_mask(m[1]), .i_ledbst_mask(m[2]),
        .i_audio_rd(rd[0]), .i_mon_rd(rd[1]), .i_ledbst_rd(rd[2]), .o_audio_status(st[0]),
        .o_mon_status(st[1]), .o_ledbst_status(st[2]), .o_int_b(int_b));
    host_reader_model host (.i_sys_clk(clk), .i_rst_b(rst_b), .i_int_b(int_b), .o_rd(rd));
    task end_of_test;
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Served bits stay set but raise nothing until the condition rises again
    always @(posedge clk) begin
        lo = 1'b0;
        for (int g = 0; g < 3; g++) begin
            ns = rd[g] ? c[g] : ms[g] | c[g];
            nv = (sv[g] | (rd[g] ? c[g] : 8'h00)) & ns & ~(c[g] & ~pc[g]);
            lo = lo | ((ns & ~m[g] & ~nv) != 8'h00);
            ms[g] <= rst_b ? ns : 8'h00;
            sv[g] <= rst_b ? nv : 8'h00;
            pc[g] <= rst_b ? c[g] : 8'h00;
        end
        mi <= rst_b ? !lo : 1'b1;
    end
    always @(negedge clk) if (rst_b) begin
        tests_run++;
        if ({st[0], st[1], st[2], int_b} !== {ms[0], ms[1], ms[2], mi}) begin
            n_fail++;
            $display("MISMATCH %0t status or request differs from model", $time);
        end
    end
    initial begin
        for (int g = 0; g < 3; g++) {c[g], m[g]} = 16'h0000;
        repeat (5) @(negedge clk);
        for (int i = 0; i < 4000; i++) begin
            rst_b = (i != 2000);
            k = $random(seed);
            // Conditions move only while idle, so a read never meets a rising condition
            for (int g = 0; g < 3; g++) begin
                if (i % 2000 > 4 && int_b === 1'b1 && k[g*2 +: 2] == 2'h0)
                    c[g] = 8'($random(seed) & $random(seed)) & {8{k[g+8]}};
                if (k[g*2+12 +: 2] == 2'h0 && k[20]) m[g] = k[g+24] ? 8'hff : 8'($random(seed));
            end
            @(negedge clk);
        end
        end_of_test;
    end
endmodule // tb_irq_status_mask
bind irq_status_mask irq_status_mask_checker chk (.*);
